// file: logic/channel_decoder.sv
// turns the analog channel select into a one-hot pin override mask.
// assumes channel codes 0..7 map onto the eight shared pins, others none.
`timescale 1ns/1ps
`default_nettype none

module channel_decoder
    import port_io_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] sel,
    output logic [7:0] ovr
);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovr <= 8'h00;
        end else if (sel < ADC_SEL_PINS) begin
            ovr <= 8'h01 << sel[2:0];
        end else begin
            ovr <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// file: logic/port_io_pkg.sv
// package for the general-purpose port block: register map, reset values,
// bus answer codes and the write command that travels to each pin group.
// assumes a 32-bit AXI4-Lite register bus and a five-bit channel select.
package port_io_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_B_DATA = 10'h001;
    localparam logic [9:0] IDX_B_DIR = 10'h005;
    localparam logic [9:0] IDX_E_DATA = 10'h008;
    localparam logic [9:0] IDX_E_DIR = 10'h00c;
    localparam logic [9:0] IDX_ADC_SEL = 10'h010;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int PORT_B_W = 8;
    localparam int PORT_E_W = 2;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [4:0] ADC_SEL_RESET = 5'h1f;
    localparam logic [4:0] ADC_SEL_PINS = 5'h08;

    // ------------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // write command to one pin group
    typedef struct packed {
        logic data_we;
        logic dir_we;
        logic [7:0] wdata;
    } port_wr_s;

endpackage

// file: logic/port_io_top.sv
// general-purpose port block: an eight-pin port shared with converter
// inputs, a two-pin port and the channel select, behind AXI4-Lite.
// assumes pins are sampled synchronously to aclk by the pad ring.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - one data latch per pin for the eight-pin port, in one register
// - direction one enables the pin driver, zero makes it an input
// - reset clears all eight direction bits, pins come up as inputs
// - reset leaves the data latches untouched
// - the converter channel selection overrides port control of its pin
// - output pins read back their latch value, except the selected converter pin, which reads zero
// - input pins read back the sampled pin level, except the selected converter pin, which reads zero
// - the data latch accepts writes whatever the direction
// - writing an input pin only updates its latch, not its read value
// - data and direction bits are readable and writable
module port_io_top
    import port_io_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    input wire logic [1:0] port_e_in,
    output logic [1:0] port_e_out,
    output logic [1:0] port_e_oe,
    output logic [7:0] analog_pin_select
);

    // ------------------------------------------------------------------
    // write channel state
    // ------------------------------------------------------------------
    logic aw_have_reg;
    logic w_have_reg;
    logic [9:0] aw_idx_reg;
    logic [31:0] w_data_reg;
    logic w_lane0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic wr_hit;
    logic aw_have_next;
    logic w_have_next;
    logic bvalid_next;

    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    // the write goes ahead once both halves are held and no answer waits
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        bvalid_next = bvalid_reg;
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
        end
        if (aw_take) begin
            aw_have_next = 1'b1;
        end
        if (w_take) begin
            w_have_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            bvalid_reg <= bvalid_next;
            // ready only while the holding slot stays empty
            awready <= !aw_have_next && !bvalid_next;
            wready <= !w_have_next && !bvalid_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_idx_reg <= 10'h000;
            w_data_reg <= 32'h0000_0000;
            w_lane0_reg <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_idx_reg <= awaddr[ADDR_W-1:2];
            end
            if (w_take) begin
                w_data_reg <= wdata;
                w_lane0_reg <= wstrb[0];
            end
        end
    end

    always_comb begin
        case (aw_idx_reg)
            IDX_B_DATA, IDX_B_DIR, IDX_E_DATA, IDX_E_DIR,
            IDX_ADC_SEL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // ------------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------------
    // only byte lane 0 carries register data; without it nothing changes
    port_wr_s b_wr;
    port_wr_s e_wr;
    logic lane_ok;
    logic [4:0] adc_sel_reg;

    // a write finishing on a reset edge must not reach the latches
    assign lane_ok = wr_fire && w_lane0_reg && aresetn;

    always_comb begin
        b_wr.data_we = lane_ok && (aw_idx_reg == IDX_B_DATA);
        b_wr.dir_we = lane_ok && (aw_idx_reg == IDX_B_DIR);
        b_wr.wdata = w_data_reg[7:0];
        e_wr.data_we = lane_ok && (aw_idx_reg == IDX_E_DATA);
        e_wr.dir_we = lane_ok && (aw_idx_reg == IDX_E_DIR);
        e_wr.wdata = w_data_reg[7:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_sel_reg <= ADC_SEL_RESET;
        end else if (lane_ok && (aw_idx_reg == IDX_ADC_SEL)) begin
            adc_sel_reg <= w_data_reg[4:0];
        end
    end

    // ------------------------------------------------------------------
    // pin groups
    // ------------------------------------------------------------------
    logic [7:0] b_dir;
    logic [7:0] b_rd;
    logic [1:0] e_dir;
    logic [1:0] e_rd;

    channel_decoder u_decoder (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(adc_sel_reg),
        .ovr(analog_pin_select)
    );

    port_pins #(.W(PORT_B_W)) u_port_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr(b_wr),
        .pin_in(port_b_in),
        .ovr(analog_pin_select),
        .pin_out(port_b_out),
        .pin_oe(port_b_oe),
        .dir(b_dir),
        .rd_val(b_rd)
    );

    port_pins #(.W(PORT_E_W)) u_port_e (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr(e_wr),
        .pin_in(port_e_in),
        .ovr(2'h0),
        .pin_out(port_e_out),
        .pin_oe(port_e_oe),
        .dir(e_dir),
        .rd_val(e_rd)
    );

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rd_word;
    logic rd_hit;
    logic ar_take;

    assign ar_take = arvalid && arready;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (araddr[ADDR_W-1:2])
            IDX_B_DATA: rd_word[7:0] = b_rd;
            IDX_B_DIR: rd_word[7:0] = b_dir;
            IDX_E_DATA: rd_word[1:0] = e_rd;
            IDX_E_DIR: rd_word[1:0] = e_dir;
            IDX_ADC_SEL: rd_word[4:0] = adc_sel_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            arready <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                arready <= 1'b0;
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && rready) begin
                rvalid_reg <= 1'b0;
                arready <= 1'b1;
            end else begin
                arready <= !rvalid_reg;
            end
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic b_rd_cycle;
    assign b_rd_cycle = ar_take && (araddr[ADDR_W-1:2] == IDX_B_DATA);

    chk_dir_cleared: assert property (
        @(posedge aclk) !aresetn |=> (b_dir == 8'h00) && (port_b_oe == 8'h00))
        else $error("direction not cleared by reset");

    chk_latch_kept: assert property (
        @(posedge aclk) !aresetn |=> $stable(port_b_out))
        else $error("data latch changed during reset");

    chk_latch_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        b_wr.data_we |=> port_b_out == $past(w_data_reg[7:0]))
        else $error("data latch missed a write");

    chk_dir_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        b_wr.dir_we |=> b_dir == $past(w_data_reg[7:0]))
        else $error("direction missed a write");

    chk_driver_enable: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 port_b_oe == ($past(b_dir) & ~$past(analog_pin_select))
        || $past(b_wr.dir_we))
        else $error("driver enable does not follow direction");

    chk_select_wins: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (analog_pin_select != 8'h00) ##1 (analog_pin_select != 8'h00)
        |-> (port_b_oe & analog_pin_select) == 8'h00)
        else $error("driver on a converter pin");

    chk_read_output: assert property (
        @(posedge aclk) disable iff (!aresetn)
        b_rd_cycle |=> (rdata[7:0] & $past(b_dir & ~analog_pin_select))
        == ($past(port_b_out) & $past(b_dir & ~analog_pin_select)))
        else $error("output pin did not read its latch");

    chk_read_input: assert property (
        @(posedge aclk) disable iff (!aresetn)
        b_rd_cycle |=> (rdata[7:0] & ~$past(b_dir))
        == ($past(port_b_in) & ~$past(b_dir | analog_pin_select)))
        else $error("input pin did not read its level");

    chk_input_unaffected: assert property (
        @(posedge aclk) disable iff (!aresetn)
        b_wr.data_we |=> (b_rd & ~b_dir) == (port_b_in & ~b_dir
        & ~analog_pin_select))
        else $error("write disturbed an input read value");

    chk_one_byte_reg: assert property (
        @(posedge aclk) disable iff (!aresetn)
        b_rd_cycle |=> rdata[31:8] == 24'h000000)
        else $error("upper bits of the data register not zero");

    chk_write_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (aw_take && w_take && !bvalid) |=> ##1 bvalid)
        else $error("write answer late");

    chk_read_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ar_take |=> rvalid)
        else $error("read answer late");

    chk_select_decode: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (adc_sel_reg < ADC_SEL_PINS)
        |=> analog_pin_select == (8'h01 << $past(adc_sel_reg[2:0])))
        else $error("wrong converter pin selected");

    chk_e_latch_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        e_wr.data_we |=> port_e_out == $past(w_data_reg[1:0]))
        else $error("small port latch missed a write");

endmodule

`default_nettype wire

// file: logic/port_pins.sv
// one group of general-purpose pins: data latch, direction bits, driver
// enable and read value. assumes pin inputs synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module port_pins
    import port_io_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire port_wr_s wr,
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] ovr,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] dir,
    output logic [W-1:0] rd_val
);

    logic [W-1:0] dir_next;

    // latch has no reset on purpose: it keeps its value across reset
    always_ff @(posedge aclk) begin
        if (wr.data_we) begin
            pin_out <= wr.wdata[W-1:0];
        end
    end

    always_comb begin
        dir_next = dir;
        if (wr.dir_we) begin
            dir_next = wr.wdata[W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir <= DIR_RESET[W-1:0];
        end else begin
            dir <= dir_next;
        end
    end

    // converter selection wins over the port driver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe <= DIR_RESET[W-1:0];
        end else begin
            pin_oe <= dir_next & ~ovr;
        end
    end

    assign rd_val = ((dir & pin_out) | (~dir & pin_in)) & ~ovr;

endmodule

`default_nettype wire

// file: verification/pin_model.sv
// pin-side model: pad level is the block's driver where enabled, else
// whatever the external circuit forces onto the pin.
// assumes the bench sets the external levels; no pull-ups on these pins.
`timescale 1ns/1ps
`default_nettype none

module pin_model (
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic [7:0] b_ext,
    input wire logic [1:0] e_out,
    input wire logic [1:0] e_oe,
    input wire logic [1:0] e_ext,
    output logic [7:0] b_in,
    output logic [1:0] e_in
);
    // an enabled driver wins over the external level
    assign b_in = (b_oe & b_out) | (~b_oe & b_ext);
    assign e_in = (e_oe & e_out) | (~e_oe & e_ext);
endmodule

`default_nettype wire

// file: verification/test_port_io_top.sv
// self-checking bench for the port block: AXI4-Lite master tasks, one task
// per scenario, pin model on the pad side.
// assumes a 250 MHz aclk and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module test_port_io_top;
    import port_io_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] b_in, b_out, b_oe, b_ext = 8'h00, an_sel;
    logic [1:0] e_in, e_out, e_oe, e_ext = 2'h0;
    logic [1:0] resp;
    logic [31:0] rd;
    int bad_count = 0, comparisons = 0;

    port_io_top i_port_io_top (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .port_b_in(b_in), .port_b_out(b_out),
        .port_b_oe(b_oe), .port_e_in(e_in), .port_e_out(e_out),
        .port_e_oe(e_oe), .analog_pin_select(an_sel));

    pin_model i_pin_model (.b_out(b_out), .b_oe(b_oe), .b_ext(b_ext),
        .e_out(e_out), .e_oe(e_oe), .e_ext(e_ext), .b_in(b_in), .e_in(e_in));

    initial begin
        forever #2 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // bus tasks and compare
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pulse_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // requests are taken from the second edge after release
        repeat (2) @(posedge aclk);
    endtask

    localparam logic [11:0] A_BD = {IDX_B_DATA, 2'b00};
    localparam logic [11:0] A_BR = {IDX_B_DIR, 2'b00};
    localparam logic [11:0] A_ED = {IDX_E_DATA, 2'b00};
    localparam logic [11:0] A_ER = {IDX_E_DIR, 2'b00};
    localparam logic [11:0] A_SEL = {IDX_ADC_SEL, 2'b00};

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        rd_reg(A_BR);
        chk("dir b", {24'h0, DIR_RESET}, rd);
        rd_reg(A_SEL);
        chk("select", {27'h0, ADC_SEL_RESET}, rd);
        chk("oe b", 32'h0, {24'h0, b_oe});
    endtask

    task automatic t_input_write();
        b_ext <= 8'ha5;
        wr(A_BD, 32'h3c);
        chk("wr resp", RESP_OKAY, resp);
        chk("latch b", 32'h3c, {24'h0, b_out});
        rd_reg(A_BD);
        chk("read input pins", 32'ha5, rd);
    endtask

    task automatic t_output();
        wr(A_BR, 32'h0f);
        chk("oe b", 32'h0f, {24'h0, b_oe});
        rd_reg(A_BR);
        chk("dir b", 32'h0f, rd);
        rd_reg(A_BD);
        chk("mixed read", 32'hac, rd);
        // lane 0 strobe off: the latch must hold
        wstrb <= 4'he;
        wr(A_BD, 32'hff);
        wstrb <= 4'h1;
        chk("strobe off resp", RESP_OKAY, resp);
        chk("latch kept", 32'h3c, {24'h0, b_out});
    endtask

    task automatic t_analog();
        wr(A_SEL, 32'h03);
        repeat (3) @(posedge aclk);
        chk("analog sel", 32'h08, {24'h0, an_sel});
        chk("oe override", 32'h07, {24'h0, b_oe});
        rd_reg(A_BD);
        chk("override read", 32'ha4, rd);
        wr(A_SEL, 32'h08);
        repeat (3) @(posedge aclk);
        chk("analog none", 32'h0, {24'h0, an_sel});
        chk("oe back", 32'h0f, {24'h0, b_oe});
        rd_reg(A_SEL);
        chk("select read", 32'h08, rd);
    endtask

    task automatic t_reset_keep();
        pulse_reset();
        chk("latch through reset", 32'h3c, {24'h0, b_out});
        chk("oe after reset", 32'h0, {24'h0, b_oe});
        rd_reg(A_BR);
        chk("dir after reset", 32'h0, rd);
    endtask

    task automatic t_port_e();
        e_ext <= 2'h0;
        wr(A_ED, 32'h3);
        wr(A_ER, 32'h1);
        chk("latch e", 32'h3, {30'h0, e_out});
        chk("oe e", 32'h1, {30'h0, e_oe});
        rd_reg(A_ED);
        chk("read e", 32'h1, rd);
        rd_reg(A_ER);
        chk("dir e", 32'h1, rd);
    endtask

    task automatic t_unmapped();
        wr(12'h008, 32'hff);
        chk("wr unmapped", RESP_SLVERR, resp);
        rd_reg(12'h008);
        chk("rd unmapped", RESP_SLVERR, resp);
        chk("latch untouched", 32'h3c, {24'h0, b_out});
    endtask

    // ----------------------------------------------------------------
    // verdict and run
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset_values();
        t_input_write();
        t_output();
        t_analog();
        t_reset_keep();
        t_port_e();
        t_unmapped();
        summarize();
    end

    // the scenarios take well under 1000 cycles
    initial begin
        #20000;
        bad_count++;
        summarize();
    end
endmodule

`default_nettype wire
